// file: common/lbpm_pkg.sv
package lbpm_pkg;
  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int LBPM_ADDR_W        = 16;
  localparam int LBPM_DATA_W        = 16;
  localparam int LBPM_SPLIT_W       = 32;
  localparam int LBPM_PIN_GRP_W     = 8;
  localparam int LBPM_DMA_CH_W      = 4;
  localparam int LBPM_SSC_CS_W      = 4;
  // Field positions of the low shared pin group in DMA mode
  localparam int LBPM_POS_DRQ_LO    = 4;
  localparam int LBPM_POS_DACK_LO   = 0;
  // Field positions of the high shared pin group in serial mode
  localparam int LBPM_POS_SCLK      = 7;
  localparam int LBPM_POS_MOSI      = 6;
  localparam int LBPM_POS_MISO      = 5;
  localparam int LBPM_POS_RSVD      = 4;
  localparam int LBPM_POS_SCS_LO    = 0;
  // ---------------------------------------------------------------
  // Reset values and drive levels
  // ---------------------------------------------------------------
  localparam logic LBPM_RST_DMA_SEL  = 1'b0;
  localparam logic LBPM_RST_SSC_SEL  = 1'b0;
  localparam logic LBPM_RST_DEC_SEL  = 1'b0;
  localparam logic LBPM_RST_SPLIT    = 1'b0;
  localparam logic LBPM_LVL_HI       = 1'b1;
  localparam logic LBPM_LVL_LO       = 1'b0;
  // ---------------------------------------------------------------
  // Line rates in kHz, selected by a 3-bit code
  // ---------------------------------------------------------------
  localparam int LBPM_RATE_SEL_W = 3;
  localparam logic [2:0] LBPM_RATE_1544 = 3'h0;
  localparam logic [2:0] LBPM_RATE_1536 = 3'h1;
  localparam logic [2:0] LBPM_RATE_2048 = 3'h2;
  localparam logic [2:0] LBPM_RATE_4096 = 3'h3;
  localparam logic [2:0] LBPM_RATE_3088 = 3'h4;
  localparam logic [2:0] LBPM_RATE_6176 = 3'h5;
  localparam logic [2:0] LBPM_RATE_8192 = 3'h6;
  localparam logic [13:0] LBPM_KHZ_1544 = 14'd1544;
  localparam logic [13:0] LBPM_KHZ_1536 = 14'd1536;
  localparam logic [13:0] LBPM_KHZ_2048 = 14'd2048;
  localparam logic [13:0] LBPM_KHZ_4096 = 14'd4096;
  localparam logic [13:0] LBPM_KHZ_3088 = 14'd3088;
  localparam logic [13:0] LBPM_KHZ_6176 = 14'd6176;
  localparam logic [13:0] LBPM_KHZ_8192 = 14'd8192;
  // Hold arbitration states
  typedef enum logic [1:0] {
    LBPM_OWN, LBPM_REQ_HOLD, LBPM_IN_HOLD, LBPM_REGAIN
  } lbpm_hold_t;
endpackage : lbpm_pkg

// file: core/lbpm_pin_mux.sv
module lbpm_pin_mux
  import lbpm_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          rst_b_in,
  // Configuration bits
  input  wire logic                          split_bus_select_in,
  input  wire logic                          local_bus_dma_select_in,
  input  wire logic                          sync_serial_select_in,
  input  wire logic                          decode_scheme_select_in,
  input  wire logic [lbpm_pkg::LBPM_RATE_SEL_W-1:0] line_rate_sel_in,
  output logic      [13:0]                   line_rate_khz_out,
  // Core side: local bus and split-bus address
  input  wire logic [lbpm_pkg::LBPM_ADDR_W-1:0]  core_addr_in,
  input  wire logic [lbpm_pkg::LBPM_DATA_W-1:0]  core_wdata_in,
  input  wire logic                          core_drive_data_in,
  input  wire logic                          core_bus_active_in,
  input  wire logic [lbpm_pkg::LBPM_SPLIT_W-1:0] split_addr_in,
  input  wire logic                          core_periph_select_in,
  input  wire logic                          core_irq_in,
  input  wire logic                          core_ready_in,
  output logic      [lbpm_pkg::LBPM_ADDR_W-1:0]  core_addr_sample_out,
  output logic      [lbpm_pkg::LBPM_DATA_W-1:0]  core_rdata_out,
  output logic                               core_slave_selected_out,
  output logic                               core_ready_seen_out,
  output logic                               core_in_hold_out,
  output logic      [1:0]                    periph_irq_active_out,
  // Local address and data pins
  input  wire logic [lbpm_pkg::LBPM_ADDR_W-1:0]  local_addr_bus_in,
  output logic      [lbpm_pkg::LBPM_ADDR_W-1:0]  local_addr_bus_out,
  output logic                               local_addr_bus_oe_out,
  input  wire logic [lbpm_pkg::LBPM_DATA_W-1:0]  local_data_bus_in,
  output logic      [lbpm_pkg::LBPM_DATA_W-1:0]  local_data_bus_out,
  output logic                               local_data_bus_oe_out,
  // Hold handshake and selects
  input  wire logic                          local_hold_request_in,
  output logic                               local_bus_request_out,
  input  wire logic                          local_hold_ack_in,
  output logic                               local_hold_ack_out,
  output logic                               local_hold_ack_oe_out,
  input  wire logic                          slave_select_in,
  output logic                               periph_select_out,
  // Ready strobe and interrupts
  input  wire logic                          local_ready_extend_in,
  output logic                               local_ready_extend_out,
  output logic                               local_ready_extend_oe_out,
  input  wire logic                          periph_irq_in_one,
  input  wire logic                          periph_irq_in_two,
  output logic                               local_irq_out,
  // Low shared pin group: general pins 0..7 or DMA lines
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_lo_pins_in,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_lo_pins_out,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_lo_pins_oe_out,
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_lo_out_in,
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_lo_oe_in,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_lo_rd_out,
  input  wire logic [lbpm_pkg::LBPM_DMA_CH_W-1:0]  dma_ack_in,
  output logic      [lbpm_pkg::LBPM_DMA_CH_W-1:0]  dma_req_out,
  // High shared pin group: general pins 8..15 or serial port
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_hi_pins_in,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_hi_pins_out,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] gp_hi_pins_oe_out,
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_hi_out_in,
  input  wire logic [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_hi_oe_in,
  output logic      [lbpm_pkg::LBPM_PIN_GRP_W-1:0] general_pins_hi_rd_out,
  input  wire logic                          ssc_master_in,
  input  wire logic                          ssc_clk_out_in,
  input  wire logic                          ssc_mosi_in,
  input  wire logic [lbpm_pkg::LBPM_SSC_CS_W-1:0]  ssc_cs_in,
  output logic                               ssc_clk_rd_out,
  output logic                               ssc_miso_rd_out,
  output logic                               ssc_mosi_rd_out,
  // Serial frame highway
  input  wire logic                          rx_line_clock_in,
  input  wire logic                          rx_frame_pulse_in,
  input  wire logic                          tx_line_clock_in,
  input  wire logic                          tx_frame_pulse_in,
  input  wire logic                          tx_bit_data_in,
  input  wire logic                          tx_bit_active_in,
  output logic                               rx_frame_start_out,
  output logic                               tx_frame_end_out,
  output logic                               tx_data_out,
  output logic                               tx_data_oe_out,
  output logic                               tx_drive_indicator
);
  import lbpm_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 48;
  logic [NSYNC-1:0] async_w;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign async_w = {local_addr_bus_in, local_data_bus_in,
                    gp_lo_pins_in, gp_hi_pins_in};
  // Pins are not related to our clock, so two stages first
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= async_w;
      s2_q <= s1_q;
    end
  end
  logic [15:0] addr_s;
  logic [15:0] data_s;
  logic [7:0]  lo_s;
  logic [7:0]  hi_s;
  assign {addr_s, data_s, lo_s, hi_s} = s2_q;

  // Single-bit control inputs and the 3-bit rate select, synchronised as a group
  localparam int NCTL = 17;
  logic [NCTL-1:0] c_w;
  logic [NCTL-1:0] c1_q;
  logic [NCTL-1:0] c2_q;
  logic [NCTL-1:0] c3_q;
  assign c_w = {split_bus_select_in, local_bus_dma_select_in,
                sync_serial_select_in, decode_scheme_select_in,
                local_hold_request_in, local_hold_ack_in,
                slave_select_in, local_ready_extend_in,
                periph_irq_in_one, periph_irq_in_two,
                rx_line_clock_in, rx_frame_pulse_in,
                tx_line_clock_in, tx_frame_pulse_in,
                line_rate_sel_in};
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    // Idle levels: hold request, slave select and ready high, rest low
    if (!rst_b_in) begin
      c1_q <= 17'h01600;
      c2_q <= 17'h01600;
      c3_q <= 17'h01600;
    end else begin
      c1_q <= c_w;
      c2_q <= c1_q;
      c3_q <= c2_q;
    end
  end
  logic split_s, dma_s, ssc_s, dec_s, hreq_s, hack_s, ssel_s, rdy_s;
  logic irq1_s, irq2_s, rxc_s, rsp_s, txc_s, tsp_s, rxc_p, txc_p;
  logic [2:0] rate_s;
  assign {split_s, dma_s, ssc_s, dec_s, hreq_s, hack_s, ssel_s, rdy_s,
          irq1_s, irq2_s, rxc_s, rsp_s, txc_s, tsp_s, rate_s} = c2_q;
  assign rxc_p = c3_q[6];
  assign txc_p = c3_q[4];

  // ---------------------------------------------------------------
  // Registered configuration
  // ---------------------------------------------------------------
  logic split_q, split_d, dma_q, dma_d, ssc_q, ssc_d, dec_q, dec_d;
  // Mode bits change only here, so every mux sees one clean edge
  always_comb begin
    split_d = split_s;
    dma_d   = dma_s;
    ssc_d   = ssc_s;
    dec_d   = dec_s;
  end
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      split_q <= LBPM_RST_SPLIT;
      dma_q   <= LBPM_RST_DMA_SEL;
      ssc_q   <= LBPM_RST_SSC_SEL;
      dec_q   <= LBPM_RST_DEC_SEL;
    end else begin
      split_q <= split_d;
      dma_q   <= dma_d;
      ssc_q   <= ssc_d;
      dec_q   <= dec_d;
    end
  end

  // Line rate lookup
  function automatic logic [13:0] rate_khz(input logic [2:0] sel);
    case (sel)
      LBPM_RATE_1544: rate_khz = LBPM_KHZ_1544;
      LBPM_RATE_1536: rate_khz = LBPM_KHZ_1536;
      LBPM_RATE_2048: rate_khz = LBPM_KHZ_2048;
      LBPM_RATE_4096: rate_khz = LBPM_KHZ_4096;
      LBPM_RATE_3088: rate_khz = LBPM_KHZ_3088;
      LBPM_RATE_6176: rate_khz = LBPM_KHZ_6176;
      LBPM_RATE_8192: rate_khz = LBPM_KHZ_8192;
      default:        rate_khz = LBPM_KHZ_2048;
    endcase
  endfunction : rate_khz

  // ---------------------------------------------------------------
  // Hold arbitration
  // ---------------------------------------------------------------
  lbpm_hold_t hold_q, hold_d;
  // The ack pin reads back our own low level for two clocks after we
  // release it, so a hold decision waits for the synchroniser
  localparam logic [1:0] SETTLE_N = 2'd2;
  logic [1:0] settle_q, settle_d;
  always_comb begin
    hold_d   = hold_q;
    settle_d = 2'd0;
    if (hold_q == LBPM_REQ_HOLD && settle_q != SETTLE_N) begin
      settle_d = settle_q + 2'd1;
    end else if (hold_q == LBPM_REQ_HOLD) begin
      settle_d = settle_q;
    end
    case (hold_q)
      LBPM_OWN:      if (!hreq_s && !core_bus_active_in) begin
        hold_d = LBPM_IN_HOLD;
      end
      LBPM_IN_HOLD:  if (hreq_s && !hack_s) begin
        hold_d = LBPM_REQ_HOLD;
      end
      LBPM_REQ_HOLD: if (settle_q == SETTLE_N && hreq_s && !hack_s) begin
        hold_d = LBPM_REGAIN;
      end else if (settle_q == SETTLE_N && hack_s) begin
        hold_d = LBPM_IN_HOLD;
      end
      LBPM_REGAIN:   hold_d = LBPM_OWN;
      default:       hold_d = LBPM_OWN;
    endcase
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic [15:0] la_o_d, ld_o_d, la_o_q, ld_o_q;
  logic        la_oe_d, ld_oe_d, la_oe_q, ld_oe_q;
  logic [7:0]  lo_o_d, lo_oe_d, hi_o_d, hi_oe_d;
  logic [7:0]  lo_o_q, lo_oe_q, hi_o_q, hi_oe_q;
  logic        held_w;
  assign held_w = (hold_q == LBPM_IN_HOLD) || (hold_q == LBPM_REQ_HOLD);
  logic        held_d;
  // Outside split mode, drop the bus on the same edge that confirms hold, never after it
  assign held_d = (hold_d == LBPM_IN_HOLD) || (hold_d == LBPM_REQ_HOLD);
  always_comb begin
    // Split mode reuses the address and data buses as one 32-bit address
    if (split_q) begin
      la_o_d  = split_addr_in[15:0];
      ld_o_d  = split_addr_in[31:16];
      la_oe_d = 1'b1;
      ld_oe_d = 1'b1;
    end else begin
      la_o_d  = core_addr_in;
      ld_o_d  = core_wdata_in;
      la_oe_d = !held_d;
      ld_oe_d = !held_d && core_drive_data_in;
    end
    // Low group: general pins or DMA request/ack lines
    if (dma_q) begin
      lo_o_d  = 8'h00;
      lo_o_d[LBPM_POS_DACK_LO +: 4] = dma_ack_in;
      lo_oe_d = 8'h0f;
    end else begin
      lo_o_d  = general_pins_lo_out_in;
      lo_oe_d = general_pins_lo_oe_in;
    end
    // High group: general pins or serial port lines
    if (ssc_q) begin
      hi_o_d = 8'h00;
      hi_o_d[LBPM_POS_SCLK] = ssc_clk_out_in;
      hi_o_d[LBPM_POS_MOSI] = ssc_mosi_in;
      hi_o_d[LBPM_POS_MISO] = ssc_mosi_in; // As slave we answer here
      hi_o_d[LBPM_POS_SCS_LO +: 4] = ssc_cs_in;
      hi_oe_d = {ssc_master_in, ssc_master_in, !ssc_master_in,
                 1'b0, 4'hf};
    end else begin
      hi_o_d  = general_pins_hi_out_in;
      hi_oe_d = general_pins_hi_oe_in;
    end
  end

  logic rxs_q, txe_q, txd_q, txoe_q, txind_q;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_q <= LBPM_OWN;
      settle_q <= 2'd0;
      la_o_q <= '0; ld_o_q <= '0; la_oe_q <= 1'b0; ld_oe_q <= 1'b0;
      lo_o_q <= '0; lo_oe_q <= '0; hi_o_q <= '0; hi_oe_q <= '0;
      rxs_q <= 1'b0; txe_q <= 1'b0;
      txd_q <= 1'b0; txoe_q <= 1'b0; txind_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      settle_q <= settle_d;
      la_o_q <= la_o_d; ld_o_q <= ld_o_d;
      la_oe_q <= la_oe_d; ld_oe_q <= ld_oe_d;
      lo_o_q <= lo_o_d; lo_oe_q <= lo_oe_d;
      hi_o_q <= hi_o_d; hi_oe_q <= hi_oe_d;
      // Frame pulses sampled on the rising line-clock edge
      rxs_q <= rxc_s && !rxc_p && rsp_s;
      txe_q <= txc_s && !txc_p && tsp_s;
      txd_q   <= tx_bit_data_in;
      txoe_q  <= tx_bit_active_in;
      txind_q <= !tx_bit_active_in;
    end
  end

  // ---------------------------------------------------------------
  // Pin and core-side outputs
  // ---------------------------------------------------------------
  assign local_addr_bus_out    = la_o_q;
  assign local_addr_bus_oe_out = la_oe_q;
  assign local_data_bus_out    = ld_o_q;
  assign local_data_bus_oe_out = ld_oe_q;
  assign gp_lo_pins_out        = lo_o_q;
  assign gp_lo_pins_oe_out     = lo_oe_q;
  assign gp_hi_pins_out        = hi_o_q;
  assign gp_hi_pins_oe_out     = hi_oe_q;
  assign core_addr_sample_out  = addr_s;
  assign core_rdata_out        = data_s;
  assign general_pins_lo_rd_out = lo_s;
  assign general_pins_hi_rd_out = hi_s;
  assign dma_req_out      = dma_q ? lo_s[LBPM_POS_DRQ_LO +: 4] : 4'h0;
  assign ssc_clk_rd_out   = ssc_q & hi_s[LBPM_POS_SCLK];
  assign ssc_miso_rd_out  = ssc_q & hi_s[LBPM_POS_MISO];
  assign ssc_mosi_rd_out  = ssc_q & hi_s[LBPM_POS_MOSI];
  // Hold ack pin: output low only in LBPM_IN_HOLD, else an input
  assign local_hold_ack_out    = LBPM_LVL_LO;
  assign local_hold_ack_oe_out = (hold_q == LBPM_IN_HOLD);
  assign local_bus_request_out = !(hold_q == LBPM_REQ_HOLD);
  assign core_in_hold_out      = held_w;
  assign core_slave_selected_out = !ssel_s;
  assign periph_select_out     = !core_periph_select_in;
  // Ready is pulled low by us while we are slave selected and our side is not ready
  assign local_ready_extend_out    = LBPM_LVL_LO;
  assign local_ready_extend_oe_out = !ssel_s && !core_ready_in;
  assign core_ready_seen_out       = rdy_s;
  // Unused inputs idle high in one scheme, low in the other
  assign periph_irq_active_out = {irq2_s ^ dec_q, irq1_s ^ dec_q};
  assign local_irq_out       = !core_irq_in;
  assign line_rate_khz_out   = rate_khz(rate_s);
  assign rx_frame_start_out  = rxs_q;
  assign tx_frame_end_out    = txe_q;
  assign tx_data_out         = txd_q;
  assign tx_data_oe_out      = txoe_q;
  assign tx_drive_indicator  = txind_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_split_lo;
    @(posedge clock_in) disable iff (!rst_b_in)
      split_q |=> local_addr_bus_out == $past(split_addr_in[15:0]);
  endproperty
  a_split_lo: assert property (p_split_lo) else $error("split low");
  property p_split_hi;
    @(posedge clock_in) disable iff (!rst_b_in)
      split_q |=> local_data_bus_out == $past(split_addr_in[31:16]);
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high");
  property p_dma_oe;
    @(posedge clock_in) disable iff (!rst_b_in)
      dma_q |=> gp_lo_pins_oe_out == 8'h0f;
  endproperty
  a_dma_oe: assert property (p_dma_oe) else $error("dma dir");
  property p_gp_lo;
    @(posedge clock_in) disable iff (!rst_b_in)
      !dma_q |=> gp_lo_pins_out == $past(general_pins_lo_out_in);
  endproperty
  a_gp_lo: assert property (p_gp_lo) else $error("gp low");
  property p_ssc_cs;
    @(posedge clock_in) disable iff (!rst_b_in)
      ssc_q |=> gp_hi_pins_oe_out[3:0] == 4'hf;
  endproperty
  a_ssc_cs: assert property (p_ssc_cs) else $error("ssc cs");
  property p_txind;
    @(posedge clock_in) disable iff (!rst_b_in)
      tx_drive_indicator == !tx_data_oe_out;
  endproperty
  a_txind: assert property (p_txind) else $error("tx ind");
  sequence s_regain;
    hold_q == LBPM_REQ_HOLD ##1 hold_q == LBPM_REGAIN;
  endsequence
  property p_req;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_regain |-> local_bus_request_out ##1 local_bus_request_out;
  endproperty
  a_req: assert property (p_req) else $error("bus req");
  property p_hold_stay;
    @(posedge clock_in) disable iff (!rst_b_in)
      (held_w && hack_s) |=> held_w;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("hold left");
endmodule : lbpm_pin_mux

// file: verification/lbpm_far_model.sv
module lbpm_far_model (
  // Bench commands
  input  wire logic        hold_want,
  input  wire logic        keep_held,
  input  wire logic        stall,
  // Device drive of shared pins
  input  wire logic        ack_o, ack_oe, rdy_o, rdy_oe, a_oe, d_oe,
  input  wire logic [15:0] a_o, d_o,
  // Resolved pin levels
  output logic             hold_req, ack_i, rdy_i,
  output logic      [15:0] a_i, d_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Far-side drivers
  // ----------------------------------------------------------
  assign hold_req = hold_want;
  // Master pulls the ack line high only while we must stay held
  assign ack_i = ack_oe ? ack_o : keep_held;
  // A stalled peer withholds ready, so the cycle stretches
  assign rdy_i = rdy_oe ? rdy_o : !stall;
  // Released lines fall to their pull-downs
  assign a_i = a_oe ? a_o : 16'h0000;
  assign d_i = d_oe ? d_o : 16'h0000;
endmodule : lbpm_far_model

// file: verification/test_local_bus_and_shared_pin_mux.sv
module test_local_bus_and_shared_pin_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import lbpm_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  typedef struct packed {logic [2:0] sel; logic [13:0] khz;} lbpm_row_t;
  logic clock_in = 1'b0;
  logic rst_b_in, split_bus_select_in, local_bus_dma_select_in;
  logic sync_serial_select_in, decode_scheme_select_in, core_drive_data_in;
  logic core_bus_active_in, core_periph_select_in, core_irq_in;
  logic core_ready_in, local_hold_request_in, local_hold_ack_in;
  logic slave_select_in, local_ready_extend_in, periph_irq_in_one;
  logic periph_irq_in_two, ssc_master_in, ssc_clk_out_in, ssc_mosi_in;
  logic rx_line_clock_in, rx_frame_pulse_in, tx_line_clock_in;
  logic tx_frame_pulse_in, tx_bit_data_in, tx_bit_active_in;
  logic hold_want, keep_held, stall;
  logic [2:0] line_rate_sel_in;
  logic [3:0] dma_ack_in, ssc_cs_in, dma_req_out;
  logic [7:0] gp_lo_pins_in, general_pins_lo_out_in, general_pins_lo_oe_in;
  logic [7:0] gp_hi_pins_in, general_pins_hi_out_in, general_pins_hi_oe_in;
  logic [7:0] gp_lo_pins_out, gp_lo_pins_oe_out, general_pins_lo_rd_out;
  logic [7:0] gp_hi_pins_out, gp_hi_pins_oe_out, general_pins_hi_rd_out;
  logic [15:0] core_addr_in, core_wdata_in, local_addr_bus_in;
  logic [15:0] local_data_bus_in, core_addr_sample_out, core_rdata_out;
  logic [15:0] local_addr_bus_out, local_data_bus_out;
  logic [31:0] split_addr_in;
  logic [13:0] line_rate_khz_out;
  logic [1:0] periph_irq_active_out, seen;
  logic core_slave_selected_out, core_ready_seen_out, core_in_hold_out;
  logic local_addr_bus_oe_out, local_data_bus_oe_out, local_bus_request_out;
  logic local_hold_ack_out, local_hold_ack_oe_out, periph_select_out;
  logic local_ready_extend_out, local_ready_extend_oe_out, local_irq_out;
  logic ssc_clk_rd_out, ssc_miso_rd_out, ssc_mosi_rd_out, rx_frame_start_out;
  logic tx_frame_end_out, tx_data_out, tx_data_oe_out, tx_drive_indicator;
  int mismatches = 0, tests_run = 0, cycles = 0, i, cnt;
  // Code 7 is unassigned and falls back to the 2048 kHz rate
  lbpm_row_t rate_tab [8] = '{'{LBPM_RATE_1544, LBPM_KHZ_1544},
    '{LBPM_RATE_1536, LBPM_KHZ_1536}, '{LBPM_RATE_2048, LBPM_KHZ_2048},
    '{LBPM_RATE_4096, LBPM_KHZ_4096}, '{LBPM_RATE_3088, LBPM_KHZ_3088},
    '{LBPM_RATE_6176, LBPM_KHZ_6176}, '{LBPM_RATE_8192, LBPM_KHZ_8192},
    '{3'h7, LBPM_KHZ_2048}};

  lbpm_pin_mux lbpm_pin_mux_i (.*);
  lbpm_far_model lbpm_far_model_i (.hold_want(hold_want),
    .keep_held(keep_held), .stall(stall), .ack_o(local_hold_ack_out),
    .ack_oe(local_hold_ack_oe_out), .rdy_o(local_ready_extend_out),
    .rdy_oe(local_ready_extend_oe_out), .a_oe(local_addr_bus_oe_out),
    .d_oe(local_data_bus_oe_out), .a_o(local_addr_bus_out),
    .d_o(local_data_bus_out), .hold_req(local_hold_request_in),
    .ack_i(local_hold_ack_in), .rdy_i(local_ready_extend_in),
    .a_i(local_addr_bus_in), .d_i(local_data_bus_in));

  always #20 clock_in = ~clock_in;
  // Hang guard, far above the 131 or so cycles the run needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Sample 1 ns after the edge so its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wt
  // Config needs two sync stages and a register before it acts
  task automatic cfg(input logic [3:0] c);
    @(posedge clock_in);
    {split_bus_select_in, local_bus_dma_select_in, sync_serial_select_in,
      decode_scheme_select_in} <= c;
    wt(5);
  endtask : cfg
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    {rst_b_in, core_bus_active_in, core_periph_select_in, core_irq_in,
      periph_irq_in_two, ssc_mosi_in, rx_line_clock_in, rx_frame_pulse_in,
      tx_line_clock_in, tx_frame_pulse_in, tx_bit_data_in, tx_bit_active_in,
      keep_held, stall, line_rate_sel_in} = '0;
    gp_hi_pins_in = 8'ha0;
    {split_bus_select_in, local_bus_dma_select_in} = 2'h0;
    {sync_serial_select_in, decode_scheme_select_in} = 2'h0;
    {slave_select_in, core_ready_in, hold_want, ssc_master_in,
      ssc_clk_out_in, periph_irq_in_one, core_drive_data_in} = '1;
    {core_addr_in, core_wdata_in, split_addr_in} = 64'h1234_abcd_89ab_cdef;
    {dma_ack_in, ssc_cs_in, gp_lo_pins_in} = 16'ha65a;
    {general_pins_lo_out_in, general_pins_lo_oe_in} = 16'h3cff;
    {general_pins_hi_out_in, general_pins_hi_oe_in} = 16'hc3f0;
    repeat (6) @(posedge clock_in);
    #1;
    chk("rst_oe", 32'h0, {local_addr_bus_oe_out, gp_lo_pins_oe_out});
    chk("rst_hi", 2'h3, {local_bus_request_out, tx_drive_indicator});
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    $display("test reset done");
    foreach (rate_tab[k]) begin
      @(posedge clock_in);
      line_rate_sel_in <= rate_tab[k].sel;
      wt(4);
      chk("rate", rate_tab[k].khz, line_rate_khz_out);
    end
    cfg(4'h0);
    chk("norm", 32'h1234_abcd, {local_addr_bus_out, local_data_bus_out});
    chk("gp", 32'h3cff_5ac3, {gp_lo_pins_out, gp_lo_pins_oe_out,
      general_pins_lo_rd_out, gp_hi_pins_out});
    chk("oe_irq", 12'hfc1, {local_addr_bus_oe_out, local_data_bus_oe_out,
      gp_hi_pins_oe_out, periph_irq_active_out});
    chk("pins_rd", 32'h1234_abcd, {core_addr_sample_out,
      core_rdata_out});
    chk("hi_rd", 11'h500, {general_pins_hi_rd_out, ssc_clk_rd_out,
      ssc_miso_rd_out, ssc_mosi_rd_out});
    cfg(4'h8);
    chk("split", 32'h89ab_cdef, {local_data_bus_out, local_addr_bus_out});
    cfg(4'h4);
    chk("dma", 16'h0fa5, {gp_lo_pins_oe_out, gp_lo_pins_out[3:0],
      dma_req_out});
    cfg(4'h3);
    chk("ssc", 16'hcf86, {gp_hi_pins_oe_out, gp_hi_pins_out[7:6], 2'b00,
      gp_hi_pins_out[3:0]});
    chk("dec", 10'h23c, {periph_irq_active_out, gp_lo_pins_out});
    chk("ssc_rd", 11'h506, {general_pins_hi_rd_out, ssc_clk_rd_out,
      ssc_miso_rd_out, ssc_mosi_rd_out});
    cfg(4'h0);
    $display("test modes done");
    @(posedge clock_in);
    hold_want <= 1'b0;
    for (i = 0; i < 8 && core_in_hold_out !== 1'b1; i++) wt(1);
    chk("held", 4'hc, {core_in_hold_out, local_hold_ack_oe_out,
      local_hold_ack_out, local_addr_bus_oe_out});
    @(posedge clock_in);
    keep_held <= 1'b1;
    hold_want <= 1'b1;
    cnt = 0;
    repeat (8) begin
      wt(1);
      cnt += (local_addr_bus_oe_out !== 1'b0);
    end
    chk("stay", 32'h0, cnt);
    @(posedge clock_in);
    keep_held <= 1'b0;
    for (i = 0; i < 10 && local_bus_request_out !== 1'b0; i++) wt(1);
    chk("req", 1'b0, local_bus_request_out);
    wt(4);
    chk("own", 2'h3, {local_bus_request_out, local_addr_bus_oe_out});
    $display("test hold done");
    @(posedge clock_in);
    {slave_select_in, core_ready_in} <= 2'h0;
    {core_periph_select_in, core_irq_in, stall} <= 3'h7;
    wt(4);
    chk("sel", 5'h18, {core_slave_selected_out, local_ready_extend_oe_out,
      local_ready_extend_out, periph_select_out, local_irq_out});
    @(posedge clock_in);
    slave_select_in <= 1'b1;
    wt(4);
    chk("stall", 2'h0, {local_ready_extend_oe_out,
      core_ready_seen_out});
    @(posedge clock_in);
    stall <= 1'b0;
    wt(4);
    chk("rdy", 2'h1, {local_ready_extend_oe_out, core_ready_seen_out});
    @(posedge clock_in);
    {tx_bit_active_in, tx_bit_data_in} <= 2'h3;
    wt(2);
    chk("tx_on", 3'h6, {tx_data_oe_out, tx_data_out, tx_drive_indicator});
    @(posedge clock_in);
    tx_bit_active_in <= 1'b0;
    wt(2);
    chk("tx_off", 2'h1, {tx_data_oe_out, tx_drive_indicator});
    @(posedge clock_in);
    {rx_frame_pulse_in, tx_frame_pulse_in} <= 2'h3;
    wt(3);
    {rx_line_clock_in, tx_line_clock_in} <= 2'h3;
    seen = 2'h0;
    repeat (6) begin
      wt(1);
      seen |= {rx_frame_start_out, tx_frame_end_out};
    end
    chk("frame", 2'h3, seen);
    $display("test highway done");
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    wt(1);
    chk("mid_rst", 10'h1, {local_data_bus_oe_out, gp_hi_pins_oe_out,
      tx_drive_indicator});
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    wt(1);
    chk("rel", 4'hc, {local_addr_bus_oe_out, local_bus_request_out,
      core_in_hold_out, core_slave_selected_out});
    $display("test reset again done");
    close_out();
  end
endmodule : test_local_bus_and_shared_pin_mux
